/* verilog/satr_pkg.sv */
package satr_pkg;
  localparam int DATA_W   = 8;
  localparam int ROM_W    = 14;
  localparam int ADDR_W   = 11;
  localparam int PTR_W    = 3;
  localparam int HIDATA_W = 6;
  localparam int NIB_W    = 4;

  localparam logic [31:0] REG_CTRL   = 32'h0000_0000;
  localparam logic [31:0] REG_WORK   = 32'h0000_0004;
  localparam logic [31:0] REG_PTR    = 32'h0000_0008;
  localparam logic [31:0] REG_HIDATA = 32'h0000_000C;
  localparam logic [31:0] REG_STATUS = 32'h0000_0010;

  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_IMM_LSB = 8;
  localparam int ST_C_BIT     = 0;
  localparam int ST_DC_BIT    = 1;
  localparam int ST_Z_BIT     = 2;
  localparam int ST_BUSY_BIT  = 3;

  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_SUB  = 2'h1;
  localparam logic [1:0] OP_TBL  = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic zero;
    logic nibbleBorrow;
    logic carry;
  } satr_flags_t;

  typedef enum logic [1:0] {
    SATR_IDLE  = 2'b00,
    SATR_FETCH = 2'b01,
    SATR_LOAD  = 2'b10
  } satr_state_t;
endpackage

/* verilog/satr_sub_alu.sv */
`timescale 1ns/1ps
// Combinational immediate-minus-working subtractor with flag outputs.
module satr_sub_alu (
  input  wire logic [satr_pkg::DATA_W-1:0] immVal,
  input  wire logic [satr_pkg::DATA_W-1:0] workVal,
  output logic [satr_pkg::DATA_W-1:0]      diff,
  output satr_pkg::satr_flags_t            flags
);
  logic [satr_pkg::DATA_W:0]  full;
  logic [satr_pkg::NIB_W:0]   low;

  always_comb
  begin
    // Carry is the inverted borrow, as two's complement add of the inverse.
    full = {1'b0, immVal} + {1'b0, ~workVal} + 9'h001;
    low  = {1'b0, immVal[satr_pkg::NIB_W-1:0]} + {1'b0, ~workVal[satr_pkg::NIB_W-1:0]} + 5'h01;
    diff = full[satr_pkg::DATA_W-1:0];
    flags.carry        = full[satr_pkg::DATA_W];
    flags.nibbleBorrow = low[satr_pkg::NIB_W];
    flags.zero         = (full[satr_pkg::DATA_W-1:0] == 8'h00);
  end
endmodule

/* verilog/subtract_and_table_read_exec.sv */
`timescale 1ns/1ps
module subtract_and_table_read_exec (
  input  wire logic                          sys_clk,
  input  wire logic                          rstn,
  input  wire logic [31:0]                   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [31:0]                   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [satr_pkg::ADDR_W-1:0]        romAddr_q,
  output logic                               romRead_q,
  input  wire logic [satr_pkg::ROM_W-1:0]    romData
);
  logic [31:0]                        awAddr_q;
  logic                               awHave_q;
  logic [31:0]                        wData_q;
  logic                               wHave_q;
  logic [satr_pkg::DATA_W-1:0]        workingRegister_q;
  logic [7:0]                         tableHighPointer_q;
  logic [satr_pkg::HIDATA_W-1:0]      tableHighData_q;
  satr_pkg::satr_flags_t              flags_q;
  satr_pkg::satr_state_t              state_q;
  logic [satr_pkg::DATA_W-1:0]        subDiff;
  satr_pkg::satr_flags_t              subFlags;
  logic                               doWrite;
  logic [1:0]                         wrOp;
  logic [satr_pkg::DATA_W-1:0]        wrImm;

  function automatic logic isAddr(input logic [31:0] a, input logic [31:0] r);
    isAddr = (a == r);
  endfunction

  satr_sub_alu uAlu (
    .immVal  (wrImm),
    .workVal (workingRegister_q),
    .diff    (subDiff),
    .flags   (subFlags)
  );

  // Write address and data are latched independently, in either order.
  assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  assign wrOp    = wData_q[satr_pkg::CTRL_OP_LSB +: 2];
  assign wrImm   = wData_q[satr_pkg::CTRL_IMM_LSB +: satr_pkg::DATA_W];

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awHave_q      <= 1'b0;
      awAddr_q      <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !awHave_q && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      else if (doWrite)
        awHave_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wHave_q      <= 1'b0;
      wData_q      <= 32'h0000_0000;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !wHave_q && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
      end
      else if (doWrite)
        wHave_q <= 1'b0;
    end
  end

  // A command written while a table read is busy is still answered but refused.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= satr_pkg::RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      if (((isAddr(awAddr_q, satr_pkg::REG_CTRL) || isAddr(awAddr_q, satr_pkg::REG_WORK)) &&
           state_q == satr_pkg::SATR_IDLE) || isAddr(awAddr_q, satr_pkg::REG_PTR))
        s_axi_bresp <= satr_pkg::RESP_OKAY;
      else
        s_axi_bresp <= satr_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      tableHighPointer_q <= 8'h00;
    else if (doWrite && isAddr(awAddr_q, satr_pkg::REG_PTR) && s_axi_wstrb[0])
      tableHighPointer_q <= wData_q[7:0];
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q           <= satr_pkg::SATR_IDLE;
      workingRegister_q <= 8'h00;
      flags_q           <= '0;
      tableHighData_q   <= 6'h00;
      romAddr_q         <= 11'h000;
      romRead_q         <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        satr_pkg::SATR_IDLE:
        begin
          romRead_q <= 1'b0;
          if (doWrite && isAddr(awAddr_q, satr_pkg::REG_CTRL) && s_axi_wstrb[1:0] == 2'h3)
          begin
            if (wrOp == satr_pkg::OP_SUB)
            begin
              workingRegister_q <= subDiff;
              flags_q           <= subFlags;
            end
            else if (wrOp == satr_pkg::OP_TBL)
            begin
              romAddr_q <= {tableHighPointer_q[satr_pkg::PTR_W-1:0], workingRegister_q};
              romRead_q <= 1'b1;
              state_q   <= satr_pkg::SATR_FETCH;
            end
            else if (wrOp == satr_pkg::OP_NONE)
              workingRegister_q <= wrImm;
          end
          else if (doWrite && isAddr(awAddr_q, satr_pkg::REG_WORK) && s_axi_wstrb[0])
            workingRegister_q <= wData_q[7:0];
        end
        satr_pkg::SATR_FETCH:
        begin
          romRead_q <= 1'b0;
          state_q   <= satr_pkg::SATR_LOAD;
        end
        satr_pkg::SATR_LOAD:
        begin
          // ROM is sampled two cycles after the address is driven, so the read spans two cycles.
          workingRegister_q <= romData[satr_pkg::DATA_W-1:0];
          tableHighData_q   <= romData[satr_pkg::ROM_W-1:satr_pkg::DATA_W];
          state_q           <= satr_pkg::SATR_IDLE;
        end
        default:
          state_q <= satr_pkg::SATR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= satr_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= satr_pkg::RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (isAddr(s_axi_araddr, satr_pkg::REG_WORK))
          s_axi_rdata[7:0] <= workingRegister_q;
        else if (isAddr(s_axi_araddr, satr_pkg::REG_PTR))
          s_axi_rdata[7:0] <= tableHighPointer_q;
        else if (isAddr(s_axi_araddr, satr_pkg::REG_HIDATA))
          s_axi_rdata[5:0] <= tableHighData_q;
        else if (isAddr(s_axi_araddr, satr_pkg::REG_STATUS))
        begin
          s_axi_rdata[satr_pkg::ST_C_BIT]    <= flags_q.carry;
          s_axi_rdata[satr_pkg::ST_DC_BIT]   <= flags_q.nibbleBorrow;
          s_axi_rdata[satr_pkg::ST_Z_BIT]    <= flags_q.zero;
          s_axi_rdata[satr_pkg::ST_BUSY_BIT] <= (state_q != satr_pkg::SATR_IDLE);
        end
        else if (!isAddr(s_axi_araddr, satr_pkg::REG_CTRL))
          s_axi_rresp <= satr_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  AST_SUB_RESULT: assert property (@(posedge sys_clk) disable iff (!rstn)
    (doWrite && isAddr(awAddr_q, satr_pkg::REG_CTRL) && wrOp == satr_pkg::OP_SUB &&
     state_q == satr_pkg::SATR_IDLE && s_axi_wstrb[1:0] == 2'h3)
    |=> workingRegister_q == $past(wrImm) - $past(workingRegister_q))
    else $error("Subtract result wrong.");

  AST_SUB_CARRY: assert property (@(posedge sys_clk) disable iff (!rstn)
    (doWrite && isAddr(awAddr_q, satr_pkg::REG_CTRL) && wrOp == satr_pkg::OP_SUB &&
     state_q == satr_pkg::SATR_IDLE && s_axi_wstrb[1:0] == 2'h3)
    |=> flags_q.carry == ($past(wrImm) >= $past(workingRegister_q)))
    else $error("Carry does not reflect borrow.");

  AST_TBL_TWO: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(romRead_q) |-> ##2 (state_q == satr_pkg::SATR_IDLE &&
     workingRegister_q == $past(romData[7:0]) && tableHighData_q == $past(romData[13:8])))
    else $error("Table read did not load in two cycles.");

  AST_TBL_FLAGS: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_q != satr_pkg::SATR_IDLE) |=> $stable(flags_q))
    else $error("Table read changed flags.");

  AST_TBL_ADDR: assert property (@(posedge sys_clk) disable iff (!rstn)
    (doWrite && isAddr(awAddr_q, satr_pkg::REG_CTRL) && wrOp == satr_pkg::OP_TBL &&
     state_q == satr_pkg::SATR_IDLE && s_axi_wstrb[1:0] == 2'h3)
    |=> romRead_q && romAddr_q ==
        {$past(tableHighPointer_q[satr_pkg::PTR_W-1:0]), $past(workingRegister_q)})
    else $error("Table address not formed from pointer and working register.");

  AST_SUB_ONE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (doWrite && isAddr(awAddr_q, satr_pkg::REG_CTRL) && wrOp == satr_pkg::OP_SUB &&
     state_q == satr_pkg::SATR_IDLE && s_axi_wstrb[1:0] == 2'h3)
    |=> state_q == satr_pkg::SATR_IDLE && !romRead_q && $stable(tableHighData_q))
    else $error("Subtract took more than one cycle or touched another register.");
endmodule

/* test/satr_rom_model.sv */
`timescale 1ns/1ps
// Program ROM that answers one cycle after each read strobe.
module satr_rom_model (
  input  wire logic [satr_pkg::ADDR_W-1:0] romAddr,
  input  wire logic                        romRead,
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  output logic [satr_pkg::ROM_W-1:0]       romData
);
  logic [satr_pkg::ROM_W-1:0] word_q;
  logic                       valid_q;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      word_q  <= 14'h0000;
      valid_q <= 1'b0;
    end
    else
    begin
      valid_q <= romRead;
      if (romRead)
        word_q <= {romAddr[10:5] ^ 6'h2C, romAddr[7:0] ^ 8'hA5};
    end
  end
  // Outside its valid cycle the word is inverted, so a late sample is caught.
  assign romData = valid_q ? word_q : ~word_q;
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd, flg;
  logic [10:0] romAddr_q, seenAddr;
  logic        romRead_q;
  logic [13:0] romData, w;
  logic [7:0]  imm, wk, diff;
  logic [15:0] subVec [5] = '{16'h0506, 16'h0605, 16'h0606, 16'h1001, 16'h00FF};
  logic [15:0] tblVec [2] = '{16'hFA34, 16'h05C3};
  int          n_errors = 0, num_checks = 0, i, k;

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (romRead_q === 1'b1)
      seenAddr <= romAddr_q;

  subtract_and_table_read_exec dut_u (.sys_clk(sys_clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .romAddr_q(romAddr_q),
    .romRead_q(romRead_q), .romData(romData));
  satr_rom_model rom_u (.romAddr(romAddr_q), .romRead(romRead_q), .sys_clk(sys_clk),
    .rstn(rstn), .romData(romData));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("TB: checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (i = 0; i < 5; i++)
    begin
      imm = subVec[i][15:8];
      wk = subVec[i][7:0];
      diff = imm - wk;
      axw(satr_pkg::REG_CTRL, {16'h0000, wk, 6'h00, satr_pkg::OP_NONE}, rsp);
      axw(satr_pkg::REG_CTRL, {16'h0000, imm, 6'h00, satr_pkg::OP_SUB}, rsp);
      chk({30'h0, rsp}, {30'h0, satr_pkg::RESP_OKAY});
      axr(satr_pkg::REG_WORK, rd, rsp);
      chk(rd, {24'h0, diff});
      axr(satr_pkg::REG_STATUS, rd, rsp);
      chk(rd, {29'h0, diff == 8'h00, imm[3:0] >= wk[3:0], imm >= wk});
    end
    $display("TB: subtract test done");
    for (i = 0; i < 2; i++)
    begin
      // The immediate minus a zero working register leaves carry and nibble flags set,
      // so a table read that clears them is caught.
      axw(satr_pkg::REG_WORK, 32'h0000_0000, rsp);
      chk({30'h0, rsp}, {30'h0, satr_pkg::RESP_OKAY});
      axw(satr_pkg::REG_CTRL, {16'h0000, tblVec[i][7:0], 6'h00, satr_pkg::OP_SUB}, rsp);
      axw(satr_pkg::REG_PTR, {24'h0, tblVec[i][15:8]}, rsp);
      axr(satr_pkg::REG_STATUS, flg, rsp);
      chk(flg, 32'h0000_0003);
      axw(satr_pkg::REG_CTRL, {24'h0, 6'h00, satr_pkg::OP_TBL}, rsp);
      k = 0;
      do
      begin
        axr(satr_pkg::REG_STATUS, rd, rsp);
        k++;
      end while (rd[satr_pkg::ST_BUSY_BIT] !== 1'b0 && k < 10);
      w = {tblVec[i][10:8] ^ 3'h5, tblVec[i][7:5] ^ 3'h4, tblVec[i][7:0] ^ 8'hA5};
      chk({21'h0, seenAddr}, {21'h0, tblVec[i][10:8], tblVec[i][7:0]});
      axr(satr_pkg::REG_WORK, rd, rsp);
      chk(rd, {24'h0, w[7:0]});
      axr(satr_pkg::REG_HIDATA, rd, rsp);
      chk(rd, {26'h0, w[13:8]});
      axr(satr_pkg::REG_STATUS, rd, rsp);
      chk(rd, 32'h0000_0003);
    end
    $display("TB: table read test done");
    axr(32'h0000_0020, rd, rsp);
    chk({rd[29:0], rsp}, {30'h0, satr_pkg::RESP_SLVERR});
    $display("TB: unmapped access test done");
    tally_and_finish();
  end

  initial
  begin
    #2000000;
    n_errors++;
    tally_and_finish();
  end
endmodule
